/* File: rtl/plbc_ctrl.sv */
// Lane split control registers for the two I/O lane units
//
// Functional notes
// - Writing 1 to unit 1 bit 3 launches its split and training.
// - After a launch, further write-1 to start is ignored; write-0 harmless.
// - Start with a new unit 1 selection in one write uses the new value.
// - Start bit always reads zero.
// - Unit 1 codes: 100 x16, 011 x8x8, 010 x8x4x4, 001 x4x4x8, 000 x4x4x4x4.
// - Code 111 takes unit 1 split from straps; 110 and 101 reserved.
// - Lane groups fixed: 15:8/7:4/3:0 for 010, 15:12/11:8/7:0 for 001.
// - Selection fields sticky over hub reset; reset exit launches retained split.
// - Writing 1 to unit 2 bit 3 launches its split, same start rules.
// - Unit 2 selection is bits 1:0; start with new value applies it.
// - Unit 2 codes: 01 one x4, 00 two x2 on 3:2 and 1:0.
`timescale 1ns/1ps
`default_nettype none
module plbc_ctrl
  import plbc_pkg::*;
(
  input  wire logic        sys_clk_in,       // 40 MHz hub core clock
  input  wire logic        srst_in,          // Hub reset, synchronous, active high
  input  wire logic        pwr_rst_in,       // Power-on reset, clears sticky fields
  input  wire logic        cfg_wr_in,        // Config write strobe
  input  wire logic        cfg_rd_in,        // Config read strobe
  input  wire logic [4:0]  cfg_dev_in,       // Config device number
  input  wire logic [2:0]  cfg_func_in,      // Config function number
  input  wire logic [11:0] cfg_off_in,       // Config byte offset
  input  wire logic [1:0]  cfg_be_in,        // Byte enables
  input  wire logic [15:0] cfg_wdata_in,     // Write data
  input  wire logic [2:0]  strap_in,         // Unit 1 split straps
  output logic [15:0]      cfg_rdata_out,    // Read data
  output logic             cfg_rvalid_out,   // Read data valid pulse
  output logic             u1_start_out,     // Unit 1 training launch pulse
  output logic [3:0]       u1_port_head_out, // Unit 1 port head mask
  output logic             u2_start_out,     // Unit 2 training launch pulse
  output logic [1:0]       u2_port_head_out  // Unit 2 port head mask
);
  logic [2:0] strap_w;

  plbc_strap_sync #(.W(3)) u_strap (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .strap_in   (strap_in),
    .strap_out  (strap_w)
  );

  // Head mask per unit 1 code; valid low for reserved codes
  function automatic logic [4:0] u1_map(input logic [2:0] code);
    unique case (code)
      PLBC_U1_X16:      u1_map = 5'h11;
      PLBC_U1_X8X8:     u1_map = 5'h15;
      PLBC_U1_X8X4X4:   u1_map = 5'h17;
      PLBC_U1_X4X4X8:   u1_map = 5'h1d;
      PLBC_U1_X4X4X4X4: u1_map = 5'h1f;
      default:          u1_map = 5'h00;
    endcase
  endfunction

  logic [2:0]  sel1_q, sel1_d;
  logic [1:0]  sel2_q, sel2_d;
  logic        hit1, hit2, wr1, wr2, go1, go2, exit_go;
  logic [2:0]  code1, res1;
  logic [1:0]  code2;
  logic [4:0]  map1;

  always_comb
  begin
    hit1 = (cfg_dev_in == PLBC_U1_DEV) && (cfg_func_in == PLBC_FUNC)
           && (cfg_off_in == PLBC_CTRL_OFF);
    hit2 = (cfg_dev_in == PLBC_U2_DEV) && (cfg_func_in == PLBC_FUNC)
           && (cfg_off_in == PLBC_CTRL_OFF);
    wr1  = cfg_wr_in && cfg_be_in[0] && hit1;
    wr2  = cfg_wr_in && cfg_be_in[0] && hit2;
    sel1_d = wr1 ? cfg_wdata_in[PLBC_U1_SEL_W-1:0] : sel1_q;
    // bit 2 of unit 2 is not stored
    sel2_d = wr2 ? cfg_wdata_in[PLBC_U2_SEL_W-1:0] : sel2_q;
  end

  // Sticky fields see only the power-on reset
  always_ff @(posedge sys_clk_in)
  begin
    if (pwr_rst_in)
    begin
      sel1_q <= PLBC_U1_SEL_RST;
      sel2_q <= PLBC_U2_SEL_RST;
    end
    else
    begin
      sel1_q <= sel1_d;
      sel2_q <= sel2_d;
    end
  end

  logic       started1_q, started1_d, started2_q, started2_d;
  logic [2:0] settle_q, settle_d;
  logic       st1_q, st1_d, st2_q, st2_d;
  logic [3:0] head1_q, head1_d;
  logic [1:0] head2_q, head2_d;

  always_comb
  begin
    // retained split launched once straps have settled after reset
    exit_go  = (settle_q == 3'h1);
    settle_d = (settle_q != 3'h0) ? settle_q - 3'h1 : settle_q;
    go1 = (wr1 && cfg_wdata_in[PLBC_START_BIT] && !started1_q) || exit_go;
    go2 = (wr2 && cfg_wdata_in[PLBC_START_BIT] && !started2_q) || exit_go;
    // same-write selection wins over the stored one
    code1 = wr1 ? cfg_wdata_in[2:0] : sel1_q;
    code2 = wr2 ? cfg_wdata_in[1:0] : sel2_q;
    res1  = (code1 == PLBC_U1_STRAP) ? strap_w : code1;
    map1  = u1_map(res1);
    started1_d = started1_q || go1;
    started2_d = started2_q || go2;
    st1_d = go1;
    st2_d = go2;
    // Reserved codes leave the current split in place rather than guess
    head1_d = (go1 && map1[4]) ? map1[3:0] : head1_q;
    // unit 2 decode, reserved codes ignored
    head2_d = head2_q;
    if (go2 && code2 == PLBC_U2_X4)
    begin
      head2_d = 2'h1;
    end
    else if (go2 && code2 == PLBC_U2_X2X2)
    begin
      head2_d = 2'h3;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || pwr_rst_in)
    begin
      started1_q <= 1'b0;
      started2_q <= 1'b0;
      settle_q   <= PLBC_SETTLE_CYC;
      st1_q      <= 1'b0;
      st2_q      <= 1'b0;
      head1_q    <= PLBC_U1_HEAD_RST;
      head2_q    <= PLBC_U2_HEAD_RST;
    end
    else
    begin
      started1_q <= started1_d;
      started2_q <= started2_d;
      settle_q   <= settle_d;
      st1_q      <= st1_d;
      st2_q      <= st2_d;
      head1_q    <= head1_d;
      head2_q    <= head2_d;
    end
  end

  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;

  always_comb
  begin
    rvalid_d = cfg_rd_in;
    rdata_d  = 16'h0000;
    if (cfg_rd_in && hit1)
    begin
      rdata_d = {13'h0000, sel1_q};
    end
    else if (cfg_rd_in && hit2)
    begin
      rdata_d = {14'h0000, sel2_q};
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || pwr_rst_in)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cfg_rdata_out    = rdata_q;
  assign cfg_rvalid_out   = rvalid_q;
  assign u1_start_out     = st1_q;
  assign u1_port_head_out = head1_q;
  assign u2_start_out     = st2_q;
  assign u2_port_head_out = head2_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in || pwr_rst_in);

  a_u1_start_launch: assert property (
    wr1 && cfg_wdata_in[3] && !started1_q |=> u1_start_out)
    else $error("unit 1 start write did not launch");
  a_no_relaunch: assert property (
    started1_q && !exit_go |=> !u1_start_out)
    else $error("unit 1 launched twice");
  a_new_sel_used: assert property (
    wr1 && cfg_wdata_in[3:0] == 4'hc && !started1_q |=> u1_port_head_out == 4'h1)
    else $error("same-write selection not applied");
  a_start_reads_zero: assert property (
    cfg_rvalid_out |-> !cfg_rdata_out[3])
    else $error("start bit read as one");
  a_split_x8x4x4: assert property (
    go1 && res1 == 3'h2 |=> u1_port_head_out == 4'h7)
    else $error("x8x4x4 grouping wrong");
  a_strap_split: assert property (
    go1 && code1 == 3'h7 && strap_w == 3'h3 |=> u1_port_head_out == 4'h5)
    else $error("strap split not used");
  a_sticky_hold: assert property (@(posedge sys_clk_in) disable iff (pwr_rst_in)
    srst_in |=> sel1_q == $past(sel1_q) && sel2_q == $past(sel2_q))
    else $error("selection lost in hub reset");
  a_exit_launch: assert property (
    $fell(srst_in) |-> ##[1:6] (u1_start_out && u2_start_out))
    else $error("no launch after reset exit");
  a_u2_decode: assert property (
    go2 && code2 == 2'h0 |=> u2_port_head_out == 2'h3 && u2_start_out)
    else $error("unit 2 x2x2 decode wrong");
  a_reserved_zero: assert property (
    cfg_rvalid_out |-> cfg_rdata_out[15:4] == 12'h000 && (!$past(hit2) || !cfg_rdata_out[2]))
    else $error("reserved bits not zero");

  c_u1_write_start: cover property (wr1 && cfg_wdata_in[3] && !started1_q);
  c_u2_write_start: cover property (wr2 && cfg_wdata_in[3] && !started2_q);
  c_relaunch_try:   cover property (wr1 && cfg_wdata_in[3] && started1_q);
endmodule
`default_nettype wire

/* File: rtl/plbc_pkg.sv */
// Package of constants for the lane split control registers
package plbc_pkg;
  // Configuration space location of each control register
  localparam logic [4:0]  PLBC_U1_DEV      = 5'h07;
  localparam logic [4:0]  PLBC_U2_DEV      = 5'h01;
  localparam logic [2:0]  PLBC_FUNC        = 3'h0;
  localparam logic [11:0] PLBC_CTRL_OFF    = 12'h190;
  // Field positions
  localparam int          PLBC_START_BIT   = 3;
  localparam int          PLBC_U1_SEL_W    = 3;
  localparam int          PLBC_U2_SEL_W    = 2;
  // Sticky reset values of the selection fields
  localparam logic [2:0]  PLBC_U1_SEL_RST  = 3'h0;
  localparam logic [1:0]  PLBC_U2_SEL_RST  = 2'h0;
  // Unit 1 selection codes
  localparam logic [2:0]  PLBC_U1_X16      = 3'h4;
  localparam logic [2:0]  PLBC_U1_X8X8     = 3'h3;
  localparam logic [2:0]  PLBC_U1_X8X4X4   = 3'h2;
  localparam logic [2:0]  PLBC_U1_X4X4X8   = 3'h1;
  localparam logic [2:0]  PLBC_U1_X4X4X4X4 = 3'h0;
  localparam logic [2:0]  PLBC_U1_STRAP    = 3'h7;
  // Unit 2 selection codes
  localparam logic [1:0]  PLBC_U2_X4       = 2'h1;
  localparam logic [1:0]  PLBC_U2_X2X2     = 2'h0;
  // Port head masks: bit i set means lane group i (lanes 4i+3:4i on unit 1, 2i+1:2i on unit 2) is a port's lowest group
  localparam logic [3:0]  PLBC_U1_HEAD_RST = 4'hf;
  localparam logic [1:0]  PLBC_U2_HEAD_RST = 2'h3;
  // Cycles after hub reset release before the retained split is launched
  localparam logic [2:0]  PLBC_SETTLE_CYC  = 3'h5;
endpackage

/* File: rtl/plbc_strap_sync.sv */
// Strap input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module plbc_strap_sync
  import plbc_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic         sys_clk_in, // Core clock
  input  wire logic         srst_in,    // Synchronous reset, active high
  input  wire logic [W-1:0] strap_in,   // Asynchronous strap pins
  output logic      [W-1:0] strap_out   // Filtered strap value
);
  initial
  begin
    if (W < 1) $error("plbc_strap_sync: W must be at least 1");
  end

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // A change counts only once second and third stages agree
      always_comb
      begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q  <= strap_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign strap_out = out_q;
endmodule
`default_nettype wire

/* File: tb/pcie_lane_bifurcation_ctrl_test.sv */
// Self-checking bench for the lane split control registers
`timescale 1ns/1ps
`default_nettype none
module pcie_lane_bifurcation_ctrl_test;
  import plbc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        pwr_rst = 1'b1;
  logic        cfg_wr  = 1'b0;
  logic        cfg_rd  = 1'b0;
  logic [4:0]  cfg_dev = 5'h00;
  logic [1:0]  cfg_be  = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [2:0]  strap   = 3'h0;
  logic [15:0] rdata;
  logic        rvalid, s1, s2;
  logic [3:0]  h1;
  logic [1:0]  h2;
  logic [3:0]  exp_h1 = 4'hf;
  logic [1:0]  exp_h2 = 2'h3;
  logic [2:0]  c1;
  logic [1:0]  c2;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          seed_val;

  always #12.5 sys_clk = ~sys_clk;

  plbc_ctrl i_plbc_ctrl (.sys_clk_in(sys_clk), .srst_in(srst), .pwr_rst_in(pwr_rst),
    .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd), .cfg_dev_in(cfg_dev), .cfg_func_in(PLBC_FUNC),
    .cfg_off_in(PLBC_CTRL_OFF), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata),
    .strap_in(strap), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .u1_start_out(s1),
    .u1_port_head_out(h1), .u2_start_out(s2), .u2_port_head_out(h2));

  function automatic logic [3:0] head1(input logic [2:0] c, input logic [3:0] prev);
    case (c)
      PLBC_U1_X16:      head1 = 4'h1;
      PLBC_U1_X8X8:     head1 = 4'h5;
      PLBC_U1_X8X4X4:   head1 = 4'h7;
      PLBC_U1_X4X4X8:   head1 = 4'hd;
      PLBC_U1_X4X4X4X4: head1 = 4'hf;
      default:          head1 = prev;
    endcase
  endfunction

  function automatic logic [1:0] head2(input logic [1:0] c, input logic [1:0] prev);
    case (c)
      PLBC_U2_X4:   head2 = 2'h1;
      PLBC_U2_X2X2: head2 = 2'h3;
      default:      head2 = prev;
    endcase
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic access(input logic w, input logic [4:0] d, input logic [1:0] b,
                        input logic [15:0] v);
    @(posedge sys_clk);
    cfg_wr <= w;
    cfg_rd <= ~w;
    cfg_dev <= d;
    cfg_be <= b;
    cfg_wdata <= v;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
  endtask

  // Every write here follows a launch, so its start bit must be ignored
  task automatic wr_refused(input logic [4:0] d, input logic [1:0] b, input logic [15:0] v);
    access(1'b1, d, b, v);
    chk("start", 16'h0, 16'({s1, s2}));
    chk("head", 16'({exp_h1, exp_h2}), 16'({h1, h2}));
  endtask

  task automatic rd_check(input logic [4:0] d, input logic [15:0] exp);
    access(1'b0, d, 2'h3, 16'h0);
    chk("rvalid", 16'h1, 16'(rvalid));
    chk("rdata", exp, rdata);
  endtask

  task automatic hub_reset(input logic pwr);
    int n;
    @(posedge sys_clk);
    srst <= 1'b1;
    pwr_rst <= pwr;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    pwr_rst <= 1'b0;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (s1 !== 1'b1 && n < 12);
    chk("launch", 16'h3, 16'({s1, s2}));
    chk("settle", 16'h1, 16'(n >= 4 && n <= 6));
    chk("head", 16'({exp_h1, exp_h2}), 16'({h1, h2}));
  endtask

  // A start write that lands before the reset-exit launch starts the unit itself
  task automatic early_start(input logic [2:0] n1, input logic [1:0] n2);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    exp_h1 = head1(n1, PLBC_U1_HEAD_RST);
    exp_h2 = head2(n2, PLBC_U2_HEAD_RST);
    access(1'b1, PLBC_U1_DEV, 2'h1, {12'h000, 1'b1, n1});
    chk("start1", 16'h1, 16'(s1));
    chk("head1", 16'(exp_h1), 16'(h1));
    access(1'b1, PLBC_U2_DEV, 2'h1, {12'h000, 2'h2, n2});
    chk("start2", 16'h1, 16'(s2));
    chk("head2", 16'(exp_h2), 16'(h2));
  endtask

  initial
  begin
    seed_val = $urandom(32'h113f);
    hub_reset(1'b1);
    early_start(PLBC_U1_X16, PLBC_U2_X4);
    for (int i = 0; i < 24; i++)
    begin
      // Walk every code first, then random picks
      c1 = (i < 8) ? 3'(i) : 3'($urandom_range(7));
      c2 = (i < 8) ? 2'(i) : 2'($urandom_range(3));
      @(posedge sys_clk);
      strap <= 3'($urandom_range(4));
      wr_refused(PLBC_U1_DEV, 2'h1, {12'($urandom), 1'b1, c1});
      wr_refused(PLBC_U2_DEV, 2'h1, {12'($urandom), 1'b1, 1'($urandom), c2});
      // Byte 0 disabled: nothing may change
      wr_refused(PLBC_U1_DEV, 2'h2, {12'h000, 1'b1, ~c1});
      rd_check(PLBC_U1_DEV, 16'(c1));
      rd_check(PLBC_U2_DEV, 16'(c2));
      access(1'b0, 5'h03, 2'h3, 16'h0);
      chk("unmapped", 16'h0, rdata & {16{rvalid}});
      // Hub reset restores the default heads, so reserved codes fall back to them
      exp_h1 = head1((c1 == PLBC_U1_STRAP) ? strap : c1, PLBC_U1_HEAD_RST);
      exp_h2 = head2(c2, PLBC_U2_HEAD_RST);
      hub_reset(1'b0);
    end
    exp_h1 = head1(PLBC_U1_SEL_RST, PLBC_U1_HEAD_RST);
    exp_h2 = head2(PLBC_U2_SEL_RST, PLBC_U2_HEAD_RST);
    hub_reset(1'b1);
    rd_check(PLBC_U1_DEV, 16'(PLBC_U1_SEL_RST));
    rd_check(PLBC_U2_DEV, 16'(PLBC_U2_SEL_RST));
    results;
  end

  initial
  begin
    #100000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
